// *** wdt_ctrl_map.svh ***
// Purpose: Register offsets, reset values, field positions and timing counts.
// Assumes: Wishbone byte addresses, one 8-bit register per aligned word.
// Notes:   Definitions only.
`ifndef WATCHDOG_MAP_SVH
`define WATCHDOG_MAP_SVH

// ****************************************
// Register map
// ****************************************
`define OFS_WATCHDOG_WAKE   4'h0
`define OFS_HALT_CONTROL    4'h4
`define OFS_PRESCALE_SELECT 4'h8
`define RST_WATCHDOG_WAKE   8'h00
`define RST_HALT_CONTROL    8'h0F
`define RST_PRESCALE_SELECT 8'h21

// ****************************************
// Field positions
// ****************************************
`define BIT_EDGE      2
`define BIT_CLK_SRC   3
`define BIT_LOW_POWER 4
`define BIT_ARM       5
`define BIT_COUNT0_HALT 0
`define BIT_COUNT1_HALT 1
`define BIT_UART_HALT 2
`define BIT_CPU_HALT  3

// ****************************************
// Timing
// ****************************************
`define CLOCK_MHZ        100
`define RC_TIMEOUT0_MS   5
`define RC_TIMEOUT1_MS   15
`define RC_TIMEOUT2_MS   25
`define RC_TIMEOUT3_MS   100
`define RESET_HOLD_MS    5
`define RC_KHZ           32
`define MS_TO_RC(ms)     ((ms) * `RC_KHZ)
`define MS_TO_CYC(ms)    ((ms) * 1000 * `CLOCK_MHZ)

`endif

// *** wdt_ctrl_pkg.sv ***
// Purpose: Types shared by the watchdog and stop/halt control block.
// Assumes: Nothing.
// Notes:   RC and hold counts live in the map header; crystal counts are module parameters.
package watchdog_ctrl_pkg;
    typedef logic [7:0]  reg8_t;
    typedef logic [31:0] count_t;
    typedef enum logic [1:0] {
        WAKE_RESET_ONLY,
        WAKE_PORT2_BIT2,
        WAKE_PORT3_BIT2,
        WAKE_PORT4_ANY
    } wake_src_e;
    typedef enum {
        WD_OFF,
        WD_COUNTING,
        WD_HOLD_RESET
    } wd_state_e;
endpackage

// *** edge_wake_detect.sv ***
// Purpose: Detect a selected edge on the stop-mode wake inputs.
// Assumes: Inputs synchronous to clock.
// Notes:   One cycle pulse per qualifying edge.
`timescale 1ns/1ps
module edge_wake_detect #(
    parameter int WIDTH = 10
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic             rising,
    output logic      [WIDTH-1:0] hit
);
    logic [WIDTH-1:0] last;

    if (WIDTH < 1) begin
        $error("edge_wake_detect WIDTH must be positive");
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            last <= '0;
            hit  <= '0;
        end else begin
            last <= pins;
            hit  <= rising ? (pins & ~last) : (~pins & last);
        end
    end
endmodule

// *** prescale_divider.sv ***
// Purpose: Crystal prescaler tick for one counter.
// Assumes: Select code 0 is divide by 2, 7 is divide by 256.
// Notes:   Tick is one cycle wide.
`timescale 1ns/1ps
module prescale_divider (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic [2:0] select,
    output logic            tick
);
    logic [7:0] count;
    logic [7:0] limit;

    always_comb begin
        limit = 8'(({1'b0, 8'h01} << ({1'b0, select} + 4'h1)) - 9'h001);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (count >= limit) begin
            count <= 8'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule

// *** watchdog_stop_halt_control.sv ***
// Purpose: Watchdog, stop-mode wake and halt-mode clock control.
// Assumes: Classic Wishbone slave, 100 MHz clock, RC tick as an input.
// Notes:   Counter, serial and interrupt logic sit outside this block.
`timescale 1ns/1ps
`include "wdt_ctrl_map.svh"

module watchdog_stop_halt_control
    import watchdog_ctrl_pkg::*;
#(
    parameter int XTAL_TIMEOUT0 = 65536,
    parameter int XTAL_TIMEOUT1 = 262144,
    parameter int XTAL_TIMEOUT2 = 1048576,
    parameter int XTAL_TIMEOUT3 = 4194304,
    parameter int RC_TIMEOUT0   = `MS_TO_RC(`RC_TIMEOUT0_MS),
    parameter int RC_TIMEOUT1   = `MS_TO_RC(`RC_TIMEOUT1_MS),
    parameter int RC_TIMEOUT2   = `MS_TO_RC(`RC_TIMEOUT2_MS),
    parameter int RC_TIMEOUT3   = `MS_TO_RC(`RC_TIMEOUT3_MS),
    parameter int RESET_HOLD    = `MS_TO_CYC(`RESET_HOLD_MS)
) (
    input  wire logic                clock,
    input  wire logic                rst_b,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [3:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                rc_tick,
    input  wire logic                crystal_input,
    input  wire logic                stop_instr,
    input  wire logic                wait_for_interrupt_instr,
    input  wire logic                irq_request,
    input  wire logic                dma_request,
    input  wire logic                port2_bit2_wake,
    input  wire logic                port3_bit2_wake,
    input  wire logic [7:0]          port4_wake,
    input  wire logic                cascade,
    output logic                     reset_pin_o,
    output logic                     reset_pin_oe_b,
    output logic                     stopped,
    output logic                     halted,
    output logic                     cpu_clock_en,
    output logic                     addr_strobe_en,
    output logic                     counter_zero_run,
    output logic                     counter_one_run,
    output logic                     uart_run,
    output logic                     counter_zero_tick,
    output logic                     counter_one_tick
);
    import watchdog_ctrl_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    reg8_t      watchdog_wake_register;
    reg8_t      halt_mode_control;
    reg8_t      prescale_select;
    wd_state_e  wd_state;
    count_t     watchdog_counter;
    count_t     hold_count;
    count_t     limit;
    logic       bus_req;
    logic       wr_lane0;
    logic       arm_write;
    logic       wd_step;
    logic       asleep;
    logic       wake_event;
    logic [9:0] wake_hits;
    logic       tick0;
    logic       tick1;
    wake_src_e  stop_wake_select;

    if (RESET_HOLD < 1 || XTAL_TIMEOUT0 < 1 || RC_TIMEOUT0 < 1) begin
        $error("watchdog counts must be positive");
    end

    function automatic count_t pick_limit(input logic xtal,
                                          input logic [1:0] code);
        count_t r;
        r = 32'h0000_0001;
        case ({xtal, code})
            3'h0:    r = count_t'(RC_TIMEOUT0);
            3'h1:    r = count_t'(RC_TIMEOUT1);
            3'h2:    r = count_t'(RC_TIMEOUT2);
            3'h3:    r = count_t'(RC_TIMEOUT3);
            3'h4:    r = count_t'(XTAL_TIMEOUT0);
            3'h5:    r = count_t'(XTAL_TIMEOUT1);
            3'h6:    r = count_t'(XTAL_TIMEOUT2);
            default: r = count_t'(XTAL_TIMEOUT3);
        endcase
        return r;
    endfunction

    // ****************************************
    // Wishbone slave
    // ****************************************
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    assign arm_write = wr_lane0 && (wb_adr_i == `OFS_WATCHDOG_WAKE)
                       && wb_dat_i[`BIT_ARM];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `OFS_WATCHDOG_WAKE:   wb_dat_o <= {24'h0, watchdog_wake_register};
                    `OFS_HALT_CONTROL:    wb_dat_o <= {24'h0, halt_mode_control};
                    `OFS_PRESCALE_SELECT: wb_dat_o <= {24'h0, prescale_select};
                    default:              wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_wake_register <= `RST_WATCHDOG_WAKE;
        end else if (wr_lane0 && wb_adr_i == `OFS_WATCHDOG_WAKE) begin
            watchdog_wake_register <= {wb_dat_i[7:6],
                watchdog_wake_register[`BIT_ARM] | wb_dat_i[`BIT_ARM],
                wb_dat_i[4:0]};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            halt_mode_control <= `RST_HALT_CONTROL;
        end else if (wr_lane0 && wb_adr_i == `OFS_HALT_CONTROL) begin
            halt_mode_control <= {4'h0, wb_dat_i[3:0]};
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale_select <= `RST_PRESCALE_SELECT;
        end else if (wr_lane0 && wb_adr_i == `OFS_PRESCALE_SELECT) begin
            prescale_select <= {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
        end
    end

    // ****************************************
    // Stop mode and wake sources
    // ****************************************
    assign stop_wake_select = wake_src_e'(watchdog_wake_register[1:0]);

    edge_wake_detect #(
        .WIDTH (10)
    ) u_wake (
        .clock  (clock),
        .rst_b  (rst_b),
        .pins   ({port4_wake, port3_bit2_wake, port2_bit2_wake}),
        .rising (watchdog_wake_register[`BIT_EDGE]),
        .hit    (wake_hits)
    );

    always_comb begin
        case (stop_wake_select)
            WAKE_RESET_ONLY: wake_event = 1'b0;
            WAKE_PORT2_BIT2: wake_event = wake_hits[0];
            WAKE_PORT3_BIT2: wake_event = wake_hits[1];
            WAKE_PORT4_ANY:  wake_event = |wake_hits[9:2];
            default:         wake_event = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stopped <= 1'b0;
        end else if (stopped && wake_event) begin
            stopped <= 1'b0;
        end else if (stop_instr && !halted) begin
            stopped <= 1'b1;
        end
    end

    // ****************************************
    // Halt mode
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            halted <= 1'b0;
        end else if (halted && (irq_request || dma_request)) begin
            halted <= 1'b0;
        end else if (wait_for_interrupt_instr
                     && !halt_mode_control[`BIT_CPU_HALT]) begin
            halted <= 1'b1;
        end
    end

    // Peripheral halt bits only matter when the CPU halt is enabled.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpu_clock_en     <= 1'b1;
            addr_strobe_en   <= 1'b1;
            counter_zero_run <= 1'b1;
            counter_one_run  <= 1'b1;
            uart_run         <= 1'b1;
        end else begin
            cpu_clock_en     <= !(halted || stopped);
            addr_strobe_en   <= !(halted || stopped);
            counter_zero_run <= !stopped && (!halted ||
                (cascade ? halt_mode_control[`BIT_COUNT1_HALT]
                         : halt_mode_control[`BIT_COUNT0_HALT]));
            counter_one_run  <= !stopped && (!halted ||
                halt_mode_control[`BIT_COUNT1_HALT]);
            uart_run         <= !stopped && (!halted ||
                halt_mode_control[`BIT_UART_HALT]);
        end
    end

    // ****************************************
    // Prescalers
    // ****************************************
    prescale_divider u_pre0 (
        .clock  (clock),
        .rst_b  (rst_b),
        .run    (counter_zero_run && !cascade),
        .select (prescale_select[2:0]),
        .tick   (tick0)
    );

    prescale_divider u_pre1 (
        .clock  (clock),
        .rst_b  (rst_b),
        .run    (counter_one_run),
        .select (prescale_select[6:4]),
        .tick   (tick1)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            counter_zero_tick <= 1'b0;
            counter_one_tick  <= 1'b0;
        end else begin
            counter_zero_tick <= tick0;
            counter_one_tick  <= tick1;
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    // The crystal input is sampled as a step enable; RC ticks come pre-made.
    assign asleep  = stopped || halted;
    assign wd_step = (watchdog_wake_register[`BIT_CLK_SRC] ? crystal_input
                      : rc_tick)
                     && (!asleep || watchdog_wake_register[`BIT_LOW_POWER]);
    assign limit   = pick_limit(watchdog_wake_register[`BIT_CLK_SRC],
                                watchdog_wake_register[7:6]);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wd_state         <= WD_OFF;
            watchdog_counter <= 32'h0000_0000;
            hold_count       <= 32'h0000_0000;
        end else begin
            case (wd_state)
                WD_OFF: begin
                    if (arm_write) begin
                        wd_state         <= WD_COUNTING;
                        watchdog_counter <= 32'h0000_0000;
                    end
                end
                WD_COUNTING: begin
                    if (arm_write) begin
                        watchdog_counter <= 32'h0000_0000;
                    end else if (wd_step) begin
                        if (watchdog_counter + 32'h1 >= limit) begin
                            wd_state   <= WD_HOLD_RESET;
                            hold_count <= 32'h0000_0000;
                        end else begin
                            watchdog_counter <= watchdog_counter + 32'h1;
                        end
                    end
                end
                WD_HOLD_RESET: begin
                    if (hold_count + 32'h1 >= count_t'(RESET_HOLD)) begin
                        wd_state         <= WD_COUNTING;
                        watchdog_counter <= 32'h0000_0000;
                    end else begin
                        hold_count <= hold_count + 32'h1;
                    end
                end
                default: wd_state <= WD_OFF;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reset_pin_o    <= 1'b1;
            reset_pin_oe_b <= 1'b1;
        end else begin
            reset_pin_o    <= 1'b0;
            reset_pin_oe_b <= !(wd_state == WD_HOLD_RESET);
        end
    end
endmodule

// *** wdt_ctrl_sva.sv ***
// Purpose: Port assertions for the watchdog and halt control block.
// Assumes: The halt register changes only through bus writes.
// Notes:   Halt bits are shadowed from the bus to judge the run outputs.
`timescale 1ns/1ps
`include "wdt_ctrl_map.svh"
module watchdog_ctrl_sva #(
    parameter int RESET_HOLD = 20
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        wait_for_interrupt_instr,
    input wire logic        irq_request,
    input wire logic        dma_request,
    input wire logic        cascade,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe_b,
    input wire logic        halted,
    input wire logic        cpu_clock_en,
    input wire logic        addr_strobe_en,
    input wire logic        counter_one_run,
    input wire logic        uart_run,
    input wire logic        counter_zero_tick
);
    // ****************
    // Shadow state
    // ****************
    logic [2:0] hreg;
    int         low_cnt;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hreg <= 3'h7;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                     wb_sel_i[0] && wb_adr_i == `OFS_HALT_CONTROL) begin
            hreg <= {wb_dat_i[`BIT_CPU_HALT], wb_dat_i[`BIT_UART_HALT],
                     wb_dat_i[`BIT_COUNT1_HALT]};
        end
    end

    // The pin hold outlasts any repetition, so it is counted here.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= reset_pin_oe_b ? 0 : low_cnt + 1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence asleep;
        halted ##1 halted;
    endsequence

    ack_follows_a: assert property (take |=> answer)
        else $error("ack missing or too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    reset_pin_a: assert property ($past(rst_b) |-> !reset_pin_o)
        else $error("reset pin level not low");
    hold_len_a: assert property ($rose(reset_pin_oe_b) |->
        low_cnt == RESET_HOLD) else $error("reset pin hold length");
    halt_enter_a: assert property (wait_for_interrupt_instr &&
        !hreg[2] && !irq_request && !dma_request |-> ##[1:2] halted)
        else $error("halt not entered");
    no_halt_a: assert property (wait_for_interrupt_instr && hreg[2] &&
        !halted |=> !halted) else $error("halt with cpu bit set");
    halt_exit_a: assert property (halted &&
        (irq_request || dma_request) |-> ##[1:2] !halted)
        else $error("halt not left");
    halt_gates_a: assert property (asleep |->
        !cpu_clock_en && !addr_strobe_en && uart_run == hreg[1] &&
        counter_one_run == hreg[0]) else $error("halt gating");
    cascade_idle_a: assert property (cascade [*4] |->
        !counter_zero_tick) else $error("counter zero ticks in cascade");
endmodule

bind watchdog_stop_halt_control watchdog_ctrl_sva #(.RESET_HOLD(RESET_HOLD))
    watchdog_ctrl_sva_inst (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wait_for_interrupt_instr,
    .irq_request, .dma_request, .cascade, .reset_pin_o, .reset_pin_oe_b,
    .halted, .cpu_clock_en, .addr_strobe_en, .counter_one_run, .uart_run,
    .counter_zero_tick);

// *** watchdog_stop_halt_control_tb.sv ***
// Purpose: Self-checking bench for the watchdog and halt control block.
// Assumes: Short watchdog and hold counts set through parameters.
// Notes:   Step inputs held high give one watchdog step per clock.
`timescale 1ns/1ps
`include "wdt_ctrl_map.svh"
module watchdog_stop_halt_control_tb;
    // ****************
    // Stimulus and tasks
    // ****************
    localparam int         HOLD = 20;
    localparam int         XT0  = 50;
    localparam int         RC_T [4] = '{`MS_TO_RC(`RC_TIMEOUT0_MS),
        `MS_TO_RC(`RC_TIMEOUT1_MS), `MS_TO_RC(`RC_TIMEOUT2_MS),
        `MS_TO_RC(`RC_TIMEOUT3_MS)};
    localparam logic [3:0] WW   = `OFS_WATCHDOG_WAKE;
    localparam logic [3:0] HC   = `OFS_HALT_CONTROL;
    localparam logic [3:0] PS   = `OFS_PRESCALE_SELECT;

    logic        clock = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
    logic        wb_we_i = 1'h0, rc_tick = 1'h1, crystal_input = 1'h0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        stop_instr = 1'h0, wait_for_interrupt_instr = 1'h0;
    logic        irq_request = 1'h0, dma_request = 1'h0, cascade = 1'h0;
    logic        port2_bit2_wake = 1'h0, port3_bit2_wake = 1'h0;
    logic [7:0]  port4_wake = 8'h00;
    logic        wb_ack_o, reset_pin_o, reset_pin_oe_b, stopped, halted;
    logic        cpu_clock_en, addr_strobe_en, counter_zero_run, uart_run;
    logic        counter_one_run, counter_zero_tick, counter_one_tick;
    int          mismatches = 0, n_tests = 0, cyc_cnt = 0, c, e;

    watchdog_stop_halt_control #(
        .XTAL_TIMEOUT0(XT0), .RESET_HOLD(HOLD)
    ) watchdog_stop_halt_control_inst (
        .clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .rc_tick, .crystal_input, .stop_instr,
        .wait_for_interrupt_instr, .irq_request, .dma_request, .port2_bit2_wake,
        .port3_bit2_wake, .port4_wake, .cascade, .reset_pin_o, .reset_pin_oe_b,
        .stopped, .halted, .cpu_clock_en, .addr_strobe_en, .counter_zero_run,
        .counter_one_run, .uart_run, .counter_zero_tick, .counter_one_tick
    );

    always #5 clock = ~clock;
    always @(posedge clock) cyc_cnt <= cyc_cnt + 1;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask

    task automatic ran_out();
        mismatches++;
        $display("wrong value at %0t: wait ran out", $time);
        print_verdict();
    endtask

    task automatic bus(input logic we, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] s = 4'h1);
        int i;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge clock);
        if (i == 20) ran_out();
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] x,
                         input string m);
        bus(1'h0, a, 8'h00);
        check(rd, {24'h0, x}, m);
    endtask

    // The pin is seen low exactly x edges after the arming write returns.
    task automatic wd_time(input int t0, input int x, input string m);
        int n;
        for (n = 0; n < 4000 && reset_pin_oe_b !== 1'h0; n++) @(posedge clock);
        if (n == 4000) ran_out();
        check(cyc_cnt - t0, x, m);
        check(reset_pin_o, 1'h0, "pin level");
        for (n = 0; n < 2000 && reset_pin_oe_b === 1'h0; n++) @(posedge clock);
        if (n == 2000) ran_out();
        check(n, HOLD, "pin hold");
    endtask

    task automatic quiet(input string m);
        int n;
        for (n = 0; n < 2 * RC_T[0] && reset_pin_oe_b !== 1'h0; n++)
            @(posedge clock);
        check(n, 2 * RC_T[0], m);
    endtask

    task automatic gap(input logic one, input int x, input string m);
        int n, k;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while ((one ? counter_one_tick : counter_zero_tick) !== 1'h1
                       && n < 600);
            if (n == 600) ran_out();
        end
        check(n, x, m);
    endtask

    task automatic pin(input int w, input logic v);
        case (w)
            1: port2_bit2_wake <= v;
            2: port3_bit2_wake <= v;
            default: port4_wake[5] <= v;
        endcase
        repeat (3) @(posedge clock);
    endtask

    task automatic halt_instr();
        wait_for_interrupt_instr <= 1'h1;
        @(posedge clock);
        wait_for_interrupt_instr <= 1'h0;
        repeat (3) @(posedge clock);
    endtask

    task automatic stop();
        stop_instr <= 1'h1;
        @(posedge clock);
        stop_instr <= 1'h0;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        rdchk(WW, `RST_WATCHDOG_WAKE, "wake reset");
        rdchk(HC, `RST_HALT_CONTROL, "halt reset");
        rdchk(PS, `RST_PRESCALE_SELECT, "prescale reset");
        bus(1'h1, WW, 8'hD7);
        rdchk(WW, 8'hD7, "wake rw");
        bus(1'h1, HC, 8'hFA);
        bus(1'h1, HC, 8'h00, 4'h0);
        rdchk(HC, 8'h0A, "halt rw");
        bus(1'h1, 4'hC, 8'hFF);
        rdchk(4'hC, 8'h00, "unmapped");
        halt_instr();
        check(halted, 1'h0, "cpu bit set");
        $display("done: registers");
        for (c = 1; c < 4; c++) begin
            for (e = 0; e < 2; e++) begin
                port2_bit2_wake <= e[0];
                port3_bit2_wake <= e[0];
                port4_wake <= {8{e[0]}};
                bus(1'h1, WW, 8'(e * 4 + c));
                stop();
                pin(c == 1 ? 2 : 1, !e[0]);
                pin(c == 1 ? 2 : 1, e[0]);
                pin(c, !e[0]);
                check(stopped, 1'h1, "no wake");
                pin(c, e[0]);
                check(stopped, 1'h0, "wake");
            end
        end
        $display("done: stop wake");
        for (c = 0; c < 8; c++) begin
            bus(1'h1, PS, 8'(c * 17));
            gap(1'h0, 2 << c, "zero divide");
            gap(1'h1, 2 << c, "one divide");
        end
        cascade <= 1'h1;
        bus(1'h1, PS, 8'h21);
        gap(1'h1, 8, "cascade divide");
        cascade <= 1'h0;
        $display("done: prescaler");
        for (c = 0; c < 2; c++) begin
            bus(1'h1, HC, c ? 8'h02 : 8'h05);
            halt_instr();
            check({halted, cpu_clock_en, addr_strobe_en, counter_zero_run,
                   counter_one_run, uart_run}, c ? 6'h22 : 6'h25,
                  "halt");
            cascade <= 1'h1;
            repeat (3) @(posedge clock);
            check(counter_zero_run, c[0], "cascade halt");
            cascade <= 1'h0;
            irq_request <= !c[0];
            dma_request <= c[0];
            repeat (3) @(posedge clock);
            check(halted, 1'h0, "halt exit");
            irq_request <= 1'h0;
            dma_request <= 1'h0;
        end
        $display("done: halt");
        for (c = 0; c < 4; c++) begin
            bus(1'h1, WW, 8'(c * 64 + 32));
            wd_time(cyc_cnt, RC_T[c], "rc time");
        end
        bus(1'h1, WW, 8'h20);
        repeat (25) @(posedge clock);
        bus(1'h1, WW, 8'h20);
        e = cyc_cnt;
        bus(1'h1, WW, 8'h00);
        rdchk(WW, 8'h20, "arm sticks");
        wd_time(e, RC_T[0], "restart");
        rc_tick <= 1'h0;
        crystal_input <= 1'h1;
        bus(1'h1, WW, 8'h28);
        wd_time(cyc_cnt, XT0, "crystal time");
        bus(1'h1, WW, 8'h20);
        quiet("rc idle");
        rc_tick <= 1'h1;
        crystal_input <= 1'h0;
        bus(1'h1, WW, 8'h20);
        halt_instr();
        quiet("halt freeze");
        irq_request <= 1'h1;
        repeat (3) @(posedge clock);
        irq_request <= 1'h0;
        bus(1'h1, WW, 8'h30);
        e = cyc_cnt;
        halt_instr();
        wd_time(e, RC_T[0], "low power");
        irq_request <= 1'h1;
        repeat (3) @(posedge clock);
        irq_request <= 1'h0;
        $display("done: watchdog");
        bus(1'h1, WW, 8'h00);
        stop();
        pin(1, 1'h0);
        pin(2, 1'h0);
        pin(3, 1'h0);
        check(stopped, 1'h1, "reset only");
        rst_b <= 1'h0;
        repeat (10) @(posedge clock);
        rst_b <= 1'h1;
        @(posedge clock);
        check(stopped, 1'h0, "reset wake");
        rdchk(WW, 8'h00, "arm cleared");
        $display("done: stop reset");
        print_verdict();
    end
endmodule
